// ===== core/pmr_pkg.sv
package pmr_pkg;
	// configuration space byte offsets
	localparam logic [7:0] PMR_OFS_CAP_ID   = 8'hA0;
	localparam logic [7:0] PMR_OFS_NEXT_PTR = 8'hA1;
	localparam logic [7:0] PMR_OFS_CAP      = 8'hA2;
	localparam logic [7:0] PMR_OFS_CSR      = 8'hA4;
	localparam logic [7:0] PMR_CAP_ID_VAL   = 8'h01;
	localparam logic [7:0] PMR_NEXT_PTR_VAL = 8'h00;
	// capabilities field positions
	localparam int PMR_CAP_COLD_WAKE = 15;
	localparam int PMR_CAP_WAKE_HI   = 14;
	localparam int PMR_CAP_WAKE_LO   = 11;
	localparam int PMR_CAP_D2        = 10;
	localparam int PMR_CAP_D1        = 9;
	localparam int PMR_CAP_RSVD_HI   = 8;
	localparam int PMR_CAP_DSI       = 5;
	localparam int PMR_CAP_AUX       = 4;
	localparam int PMR_CAP_CLK       = 3;
	localparam int PMR_CAP_VER_HI    = 2;
	localparam logic [2:0] PMR_VER_R11 = 3'h2;
	localparam logic [2:0] PMR_VER_R12 = 3'h3;
	localparam logic PMR_COLD_WAKE_RST = 1'b1;
	// control/status field positions
	localparam int PMR_CSR_STATUS   = 15;
	localparam int PMR_CSR_SCALE_HI = 14;
	localparam int PMR_CSR_ENABLE   = 8;
	localparam int PMR_CSR_RSVD_HI  = 7;
	localparam int PMR_CSR_PS_HI    = 1;
	localparam logic [15:0] PMR_CSR_RST = 16'h0000;
	// internal reset length after leaving the hot off state
	localparam int PMR_FUNC_RST_CYCLES = 4;
	typedef enum logic [1:0] {
		PMR_D0    = 2'h0,
		PMR_D1    = 2'h1,
		PMR_D2    = 2'h2,
		PMR_D3HOT = 2'h3
	} pmr_pstate_t;
endpackage

// ===== core/pmr_wake_ctl.sv
`timescale 1ns/10ps
module pmr_wake_ctl (
	// clock and resets
	input  wire logic i_core_clk,
	input  wire logic i_rstn,
	input  wire logic i_bus_reset_n,
	// event and software access
	input  wire logic i_event,
	input  wire logic i_status_clr,
	input  wire logic i_enable_wr,
	input  wire logic i_enable_val,
	// state
	output logic      o_status,
	output logic      o_enable,
	output logic      o_wake_n
);
	logic status_d;
	logic enable_d;

	always_comb begin
		status_d = o_status;
		if (!i_bus_reset_n && !o_enable) begin
			status_d = 1'b0;
		end else if (i_event) begin
			status_d = 1'b1;
		end else if (i_status_clr) begin
			status_d = 1'b0;
		end
		enable_d = i_enable_wr ? i_enable_val : o_enable;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_status <= 1'b0;
		end else begin
			o_status <= status_d;
		end
	end

	// global reset only; bus reset leaves it alone
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_enable <= 1'b0;
		end else begin
			o_enable <= enable_d;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wake_n <= 1'b1;
		end else begin
			o_wake_n <= !(status_d && enable_d);
		end
	end

	property p_set;
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_event && i_bus_reset_n |=> o_status;
	endproperty
	a_set: assert property (p_set) else $error("status not set");

	property p_clr;
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_status_clr && !i_event |=> !o_status && o_wake_n;
	endproperty
	a_clr: assert property (p_clr) else $error("status not cleared");

	property p_gate;
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_wake_n == !(o_status && o_enable);
	endproperty
	a_gate: assert property (p_gate) else $error("wake pin wrong");

	property p_keep_en;
		@(posedge i_core_clk) disable iff (!i_rstn)
		!i_bus_reset_n && !i_enable_wr |=> $stable(o_enable);
	endproperty
	a_keep_en: assert property (p_keep_en) else $error("enable lost");

	property p_ctx;
		@(posedge i_core_clk) disable iff (!i_rstn)
		!i_bus_reset_n && !o_enable |=> !o_status;
	endproperty
	a_ctx: assert property (p_ctx) else $error("context kept");
endmodule

// ===== core/pmr_d3_exit.sv
`timescale 1ns/10ps
module pmr_d3_exit #(
	parameter int CYCLES = pmr_pkg::PMR_FUNC_RST_CYCLES
) (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	// power state write
	input  wire logic       i_ps_wr,
	input  wire logic [1:0] i_ps_new,
	input  wire logic [1:0] i_ps_cur,
	// internal function reset
	output logic            o_func_reset
);
	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          leave_d3;

	assign leave_d3 = i_ps_wr && i_ps_cur == pmr_pkg::PMR_D3HOT
		&& i_ps_new == pmr_pkg::PMR_D0;

	always_comb begin
		cnt_d = cnt_q;
		if (leave_d3) begin
			cnt_d = CW'(CYCLES);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= '0;
			o_func_reset <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_func_reset <= cnt_d != '0;
		end
	end
endmodule

// ===== core/pmr_regs.sv
`timescale 1ns/10ps
module pmr_regs #(
	parameter logic AUX_SUPPLY           = 1'b0,
	parameter logic WAKE_NEEDS_BUS_CLOCK = 1'b0,
	parameter int   FUNC_RST_CYCLES      = pmr_pkg::PMR_FUNC_RST_CYCLES
) (
	// clock and global reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	// bus reset
	input  wire logic        i_bus_reset_n,
	// configuration access
	input  wire logic        i_cfg_rd,
	input  wire logic        i_cfg_wr,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [3:0]  i_cfg_be,
	input  wire logic [31:0] i_cfg_wdata,
	output logic [31:0]      o_cfg_rdata,
	output logic             o_cfg_ack,
	// device side
	input  wire logic        i_pm_revision_select,
	input  wire logic        i_wake_event,
	output logic             o_wake_n,
	output logic [1:0]       o_power_state,
	output logic             o_func_reset
);
	// bit offsets of each register inside its configuration dword
	localparam int CB = 8 * int'(pmr_pkg::PMR_OFS_CAP[1:0]);
	localparam int SB = 8 * int'(pmr_pkg::PMR_OFS_CSR[1:0]);
	localparam int IB = 8 * int'(pmr_pkg::PMR_OFS_CAP_ID[1:0]);
	localparam int NB = 8 * int'(pmr_pkg::PMR_OFS_NEXT_PTR[1:0]);

	if (FUNC_RST_CYCLES < 1 || FUNC_RST_CYCLES > 255) begin : g_chk
		$error("FUNC_RST_CYCLES out of range");
	end
	if (CB + 16 > 32 || SB + 16 > 32) begin : g_chk_ofs
		$error("register straddles a dword");
	end

	function automatic logic dw_hit(
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return addr[7:2] == ofs[7:2];
	endfunction

	function automatic logic lane_on(
		input logic [3:0] be,
		input int         pos
	);
		logic [4:0] p;
		p = 5'(pos);
		return be[p[4:3]];
	endfunction

	logic        cold_wake_q;
	logic [1:0]  ps_q;
	logic        wake_status;
	logic        wake_enable;
	logic        wr_cap;
	logic        wr_csr;
	logic        rd_cap;
	logic        rd_csr;
	logic        ps_wr;
	logic        status_clr;
	logic        enable_wr;
	logic [15:0] cap_val;
	logic [15:0] csr_val;
	logic [31:0] rdata_d;

	assign wr_cap = i_cfg_wr && dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CAP);
	assign wr_csr = i_cfg_wr && dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CSR);
	assign rd_cap = i_cfg_rd && dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CAP);
	assign rd_csr = i_cfg_rd && dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CSR);

	assign ps_wr = wr_csr
		&& lane_on(i_cfg_be, SB + pmr_pkg::PMR_CSR_PS_HI);
	assign enable_wr = wr_csr
		&& lane_on(i_cfg_be, SB + pmr_pkg::PMR_CSR_ENABLE);
	// write-one-to-clear; a zero leaves the status alone
	assign status_clr = wr_csr
		&& lane_on(i_cfg_be, SB + pmr_pkg::PMR_CSR_STATUS)
		&& i_cfg_wdata[SB + pmr_pkg::PMR_CSR_STATUS];

	// firmware clears this when no auxiliary supply is fitted
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cold_wake_q <= pmr_pkg::PMR_COLD_WAKE_RST;
		end else if (wr_cap
			&& lane_on(i_cfg_be, CB + pmr_pkg::PMR_CAP_COLD_WAKE)) begin
			cold_wake_q <= i_cfg_wdata[CB + pmr_pkg::PMR_CAP_COLD_WAKE];
		end
	end

	// the internal hot-off exit reset does not reach this field
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ps_q <= pmr_pkg::PMR_CSR_RST[pmr_pkg::PMR_CSR_PS_HI:0];
		end else if (!i_bus_reset_n) begin
			ps_q <= pmr_pkg::PMR_D0;
		end else if (ps_wr) begin
			ps_q <= i_cfg_wdata[SB + pmr_pkg::PMR_CSR_PS_HI -: 2];
		end
	end
	assign o_power_state = ps_q;

	pmr_wake_ctl u_wake (
		.i_core_clk    (i_core_clk),
		.i_rstn        (i_rstn),
		.i_bus_reset_n (i_bus_reset_n),
		.i_event       (i_wake_event),
		.i_status_clr  (status_clr),
		.i_enable_wr   (enable_wr),
		.i_enable_val  (i_cfg_wdata[SB + pmr_pkg::PMR_CSR_ENABLE]),
		.o_status      (wake_status),
		.o_enable      (wake_enable),
		.o_wake_n      (o_wake_n)
	);

	pmr_d3_exit #(
		.CYCLES (FUNC_RST_CYCLES)
	) u_d3_exit (
		.i_core_clk   (i_core_clk),
		.i_rstn       (i_rstn),
		.i_ps_wr      (ps_wr && i_bus_reset_n),
		.i_ps_new     (i_cfg_wdata[SB + pmr_pkg::PMR_CSR_PS_HI -: 2]),
		.i_ps_cur     (ps_q),
		.o_func_reset (o_func_reset)
	);

	always_comb begin
		cap_val = 16'h0000;
		cap_val[pmr_pkg::PMR_CAP_COLD_WAKE] = cold_wake_q;
		cap_val[pmr_pkg::PMR_CAP_WAKE_HI:pmr_pkg::PMR_CAP_WAKE_LO] = 4'hF;
		cap_val[pmr_pkg::PMR_CAP_D2] = 1'b1;
		cap_val[pmr_pkg::PMR_CAP_D1] = 1'b1;
		// aux indicator only means something with cold wake support
		cap_val[pmr_pkg::PMR_CAP_AUX] = AUX_SUPPLY && cold_wake_q;
		cap_val[pmr_pkg::PMR_CAP_CLK] = WAKE_NEEDS_BUS_CLOCK;
		cap_val[pmr_pkg::PMR_CAP_VER_HI:0] = i_pm_revision_select
			? pmr_pkg::PMR_VER_R12 : pmr_pkg::PMR_VER_R11;
	end

	always_comb begin
		csr_val = pmr_pkg::PMR_CSR_RST;
		csr_val[pmr_pkg::PMR_CSR_STATUS] = wake_status;
		csr_val[pmr_pkg::PMR_CSR_ENABLE] = wake_enable;
		csr_val[pmr_pkg::PMR_CSR_PS_HI:0] = ps_q;
	end

	// unmapped dwords answer with zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_cap) begin
			rdata_d[CB +: 16] = cap_val;
			rdata_d[IB +: 8] = pmr_pkg::PMR_CAP_ID_VAL;
			rdata_d[NB +: 8] = pmr_pkg::PMR_NEXT_PTR_VAL;
		end else if (rd_csr) begin
			rdata_d[SB +: 16] = csr_val;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cfg_rdata <= 32'h0000_0000;
		end else if (i_cfg_rd) begin
			o_cfg_rdata <= rdata_d;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cfg_ack <= 1'b0;
		end else begin
			o_cfg_ack <= i_cfg_rd || i_cfg_wr;
		end
	end

	sequence s_rd_cap;
		i_cfg_rd && dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CAP);
	endsequence

	sequence s_rd_csr;
		i_cfg_rd && dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CSR);
	endsequence

	sequence s_wr_ps;
		i_cfg_wr && dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CSR)
		&& i_cfg_be[SB / 8];
	endsequence

	sequence s_d3_to_d0;
		s_wr_ps ##0 (i_bus_reset_n && ps_q == pmr_pkg::PMR_D3HOT
		&& i_cfg_wdata[SB + 1 -: 2] == pmr_pkg::PMR_D0);
	endsequence

	property p_ack;
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_cfg_rd || i_cfg_wr |=> o_cfg_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("no config ack");

	property p_cap_d1;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_rd_cap |=> o_cfg_rdata[CB + 9] && o_cfg_rdata[CB + 10];
	endproperty
	a_cap_d1: assert property (p_cap_d1) else $error("D1 bit low");

	property p_cap_rsvd;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_rd_cap |=> o_cfg_rdata[CB + 8 -: 3] == 3'h0
			&& !o_cfg_rdata[CB + 5];
	endproperty
	a_cap_rsvd: assert property (p_cap_rsvd) else $error("cap rsvd set");

	property p_cap_aux;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_rd_cap ##0 (!cold_wake_q || !AUX_SUPPLY)
			|=> !o_cfg_rdata[CB + 4];
	endproperty
	a_cap_aux: assert property (p_cap_aux) else $error("aux bit set");

	property p_cap_clk;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_rd_cap |=> o_cfg_rdata[CB + 3] == WAKE_NEEDS_BUS_CLOCK;
	endproperty
	a_cap_clk: assert property (p_cap_clk) else $error("clock bit wrong");

	property p_cap_ver;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_rd_cap |=> o_cfg_rdata[CB + 2 -: 3]
			== ($past(i_pm_revision_select) ? 3'h3 : 3'h2);
	endproperty
	a_cap_ver: assert property (p_cap_ver) else $error("bad version");

	property p_cold_wr;
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_cfg_wr && dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CAP)
			&& i_cfg_be[(CB + 15) / 8]
			|=> cold_wake_q == $past(i_cfg_wdata[CB + 15]);
	endproperty
	a_cold_wr: assert property (p_cold_wr) else $error("cold bit not written");

	property p_csr_rsvd;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_rd_csr |=> o_cfg_rdata[SB + 14 -: 6] == 6'h00
			&& o_cfg_rdata[SB + 7 -: 6] == 6'h00
			&& o_cfg_rdata[31:SB + 16] == '0;
	endproperty
	a_csr_rsvd: assert property (p_csr_rsvd) else $error("csr rsvd set");

	property p_ps_wr;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_wr_ps ##0 i_bus_reset_n
			|=> o_power_state == $past(i_cfg_wdata[SB + 1 -: 2]);
	endproperty
	a_ps_wr: assert property (p_ps_wr) else $error("state not written");

	property p_keep;
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_func_reset && !i_cfg_wr && i_bus_reset_n && !i_wake_event
			|=> $stable(ps_q) && $stable(wake_status)
			&& $stable(wake_enable);
	endproperty
	a_keep: assert property (p_keep) else $error("csr lost");

	property p_d3_exit;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_d3_to_d0 |=> o_func_reset ##1 (o_func_reset || FUNC_RST_CYCLES == 1);
	endproperty
	a_d3_exit: assert property (p_d3_exit) else $error("no function reset");

	property p_w0;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_wr_ps ##0 (!i_cfg_wdata[SB + 15] && !i_wake_event
			&& i_bus_reset_n) |=> $stable(wake_status);
	endproperty
	a_w0: assert property (p_w0) else $error("zero write changed status");

	property p_pin;
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_wake_event && i_bus_reset_n && wake_enable && !enable_wr
			|=> !o_wake_n;
	endproperty
	a_pin: assert property (p_pin) else $error("wake pin idle");

	property p_cap_id;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_rd_cap |=> o_cfg_rdata[IB +: 8] == pmr_pkg::PMR_CAP_ID_VAL
			&& o_cfg_rdata[NB +: 8] == pmr_pkg::PMR_NEXT_PTR_VAL;
	endproperty
	a_cap_id: assert property (p_cap_id) else $error("cap header wrong");

	property p_csr_data;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_rd_csr
			|=> o_cfg_rdata[SB + pmr_pkg::PMR_CSR_SCALE_HI -: 6] == 6'h00;
	endproperty
	a_csr_data: assert property (p_csr_data) else $error("data set");

	property p_csr_rd;
		@(posedge i_core_clk) disable iff (!i_rstn)
		s_rd_csr |=> o_cfg_rdata[SB +: 16] == {$past(wake_status), 6'h00,
			$past(wake_enable), 6'h00, $past(ps_q)};
	endproperty
	a_csr_rd: assert property (p_csr_rd) else $error("csr wrong");

	// read data must stand until the next read
	property p_rd_keep;
		@(posedge i_core_clk) disable iff (!i_rstn)
		!i_cfg_rd |=> $stable(o_cfg_rdata);
	endproperty
	a_rd_keep: assert property (p_rd_keep) else $error("read data moved");

	property p_ack_once;
		@(posedge i_core_clk) disable iff (!i_rstn)
		!i_cfg_rd && !i_cfg_wr |=> !o_cfg_ack;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("stray ack");

	property p_bus_ps;
		@(posedge i_core_clk) disable iff (!i_rstn)
		!i_bus_reset_n |=> o_power_state == pmr_pkg::PMR_D0;
	endproperty
	a_bus_ps: assert property (p_bus_ps) else $error("state kept");

	property p_unmapped;
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_cfg_rd && !dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CAP)
			&& !dw_hit(i_cfg_addr, pmr_pkg::PMR_OFS_CSR)
			|=> o_cfg_rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data");
endmodule

// ===== bench/pmr_host_model.sv
`timescale 1ns/10ps
module pmr_host_model (
	// clock
	input  wire logic        i_core_clk,
	// request
	output logic             o_cfg_rd,
	output logic             o_cfg_wr,
	output logic [7:0]       o_cfg_addr,
	output logic [3:0]       o_cfg_be,
	output logic [31:0]      o_cfg_wdata,
	// answer
	input  wire logic [31:0] i_cfg_rdata,
	input  wire logic        i_cfg_ack
);
	initial begin
		o_cfg_rd    = 1'b0;
		o_cfg_wr    = 1'b0;
		o_cfg_addr  = 8'h00;
		o_cfg_be    = 4'h0;
		o_cfg_wdata = 32'h0;
	end

	// strobe stands one cycle; the port takes it at that rising edge
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [3:0] be, input logic [31:0] d,
			output logic [31:0] q, output logic ok);
		int n;
		@(negedge i_core_clk);
		o_cfg_rd    = !w;
		o_cfg_wr    = w;
		o_cfg_addr  = a;
		o_cfg_be    = be;
		o_cfg_wdata = d;
		@(negedge i_core_clk);
		o_cfg_rd    = 1'b0;
		o_cfg_wr    = 1'b0;
		// released lines flip so stale values cannot pass by luck
		o_cfg_addr  = ~a;
		o_cfg_be    = ~be;
		o_cfg_wdata = ~d;
		n = 0;
		while (i_cfg_ack !== 1'b1 && n < 4) begin
			@(negedge i_core_clk);
			n++;
		end
		ok = (i_cfg_ack === 1'b1);
		q  = i_cfg_rdata;
	endtask
endmodule

// ===== bench/pci_power_mgmt_regs_tb_top.sv
`timescale 1ns/10ps
module pci_power_mgmt_regs_tb_top;
	// short pulse keeps the run brief
	localparam int RST_LEN = 3;
	localparam logic [7:0] A_CAP = pmr_pkg::PMR_OFS_CAP_ID;
	localparam logic [7:0] A_CSR = pmr_pkg::PMR_OFS_CSR;

	logic        i_core_clk;
	logic        i_rstn;
	logic        i_bus_reset_n;
	logic        i_pm_revision_select;
	logic        i_wake_event;
	logic        cfg_rd;
	logic        cfg_wr;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata;
	logic [31:0] cfg_rdata;
	logic        cfg_ack;
	logic        o_wake_n;
	logic [1:0]  o_power_state;
	logic        o_func_reset;
	logic [31:0] rd_q;
	logic        ok;
	int          errors = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          n;

	pmr_regs #(.FUNC_RST_CYCLES(RST_LEN)) uut (
		.i_core_clk          (i_core_clk),
		.i_rstn              (i_rstn),
		.i_bus_reset_n       (i_bus_reset_n),
		.i_cfg_rd            (cfg_rd),
		.i_cfg_wr            (cfg_wr),
		.i_cfg_addr          (cfg_addr),
		.i_cfg_be            (cfg_be),
		.i_cfg_wdata         (cfg_wdata),
		.o_cfg_rdata         (cfg_rdata),
		.o_cfg_ack           (cfg_ack),
		.i_pm_revision_select(i_pm_revision_select),
		.i_wake_event        (i_wake_event),
		.o_wake_n            (o_wake_n),
		.o_power_state       (o_power_state),
		.o_func_reset        (o_func_reset)
	);

	pmr_host_model host (
		.i_core_clk (i_core_clk),
		.o_cfg_rd   (cfg_rd),
		.o_cfg_wr   (cfg_wr),
		.o_cfg_addr (cfg_addr),
		.o_cfg_be   (cfg_be),
		.o_cfg_wdata(cfg_wdata),
		.i_cfg_rdata(cfg_rdata),
		.i_cfg_ack  (cfg_ack)
	);

	initial i_core_clk = 1'b0;
	always #25 i_core_clk = ~i_core_clk;

	task automatic report_and_stop();
		if (errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// whole run needs well under a thousand cycles
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be,
			input logic [31:0] d);
		host.xfer(1'b1, a, be, d, rd_q, ok);
		chk({31'h0, ok}, 32'h1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 4'h0, 32'h0, rd_q, ok);
		chk({31'h0, ok}, 32'h1);
		chk(rd_q, exp);
	endtask

	task automatic pulse(input logic ev);
		@(negedge i_core_clk);
		if (ev) i_wake_event = 1'b1;
		else i_bus_reset_n = 1'b0;
		@(negedge i_core_clk);
		i_wake_event  = 1'b0;
		i_bus_reset_n = 1'b1;
	endtask

	function automatic logic [31:0] cap(input logic cold, input logic rev);
		return {cold, 6'h3F, 4'h0, 1'b0, 1'b0, rev ? 3'h3 : 3'h2, 16'h0001};
	endfunction

	initial begin
		i_rstn               = 1'b0;
		i_bus_reset_n        = 1'b1;
		i_pm_revision_select = 1'b0;
		i_wake_event         = 1'b0;
		repeat (3) @(negedge i_core_clk);
		i_rstn = 1'b1;
		chk({31'h0, o_wake_n}, 32'h1);
		rd(A_CAP, cap(1'b1, 1'b0));
		rd(A_CSR, 32'h0);
		@(negedge i_core_clk);
		i_pm_revision_select = 1'b1;
		rd(A_CAP, cap(1'b1, 1'b1));
		i_pm_revision_select = 1'b0;
		rd(A_CAP, cap(1'b1, 1'b0));
		wr(A_CAP, 4'hF, 32'hFFFFFFFF);
		rd(A_CAP, cap(1'b1, 1'b0));
		wr(A_CAP, 4'hC, 32'h0);
		rd(A_CAP, cap(1'b0, 1'b0));
		wr(8'hA8, 4'hF, 32'hFFFFFFFF);
		rd(8'hA8, 32'h0);
		wr(A_CSR, 4'hF, 32'hFFFFFFFF);
		rd(A_CSR, 32'h0103);
		// leaving hot off for D0 fires the internal reset
		wr(A_CSR, 4'h1, 32'h0);
		n = 0;
		while (o_func_reset === 1'b1 && n < 10) begin
			n++;
			@(negedge i_core_clk);
		end
		chk(n, RST_LEN);
		rd(A_CSR, 32'h0100);
		for (int i = 0; i < 4; i++) begin
			wr(A_CSR, 4'h1, 32'(i));
			chk({30'h0, o_power_state}, 32'(i));
			rd(A_CSR, 32'h0100 | 32'(i));
		end
		// no hot-off exit among these steps, so no internal reset
		chk({31'h0, o_func_reset}, 32'h0);
		pulse(1'b1);
		@(negedge i_core_clk);
		chk({31'h0, o_wake_n}, 32'h0);
		rd(A_CSR, 32'h8103);
		wr(A_CSR, 4'h2, 32'h0100);
		rd(A_CSR, 32'h8103);
		chk({31'h0, o_wake_n}, 32'h0);
		wr(A_CSR, 4'h2, 32'h8100);
		rd(A_CSR, 32'h0103);
		chk({31'h0, o_wake_n}, 32'h1);
		wr(A_CSR, 4'h2, 32'h0);
		pulse(1'b1);
		@(negedge i_core_clk);
		chk({31'h0, o_wake_n}, 32'h1);
		rd(A_CSR, 32'h8003);
		pulse(1'b0);
		rd(A_CSR, 32'h0);
		wr(A_CSR, 4'h2, 32'h0100);
		pulse(1'b1);
		pulse(1'b0);
		rd(A_CSR, 32'h8100);
		chk({31'h0, o_wake_n}, 32'h0);
		@(negedge i_core_clk);
		i_rstn = 1'b0;
		@(negedge i_core_clk);
		i_rstn = 1'b1;
		rd(A_CSR, 32'h0);
		rd(A_CAP, cap(1'b1, 1'b0));
		chk({31'h0, o_wake_n}, 32'h1);
		report_and_stop();
	end
endmodule
